// *** erl_event_unit.sv ***
// Purpose: recovery counting and latching for one supervised event
// Assumes: tick is a one-cycle pulse, event input synchronous
// Notes:   counter is private to this instance
`default_nettype none

module erl_event_unit
  import erl_pkg::*;
#(
  parameter int LW = ERL_LIMIT_W
)
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          tick,
  input  wire logic          active,
  input  wire logic [LW-1:0] max_limit,
  input  wire logic [LW:0]   clear_len,
  input  wire logic          evt_reset,
  output logic               latched,
  output logic [LW-1:0]      rec_count
);

  logic          active_q;
  logic          armed;
  logic [LW:0]   clear_cnt;
  logic          occur;
  logic          recover;
  logic          latch_set;

  assign occur     = active & ~active_q;
  // compare with >= so a window shortened in mid-clear still ends the period
  assign recover   = ~active & armed & tick & (clear_cnt >= clear_len);
  assign latch_set = occur & (rec_count >= max_limit);

  // ----------------------------------------------------------------------
  // clear-time measurement
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      active_q  <= 1'b0;
      armed     <= 1'b0;
      clear_cnt <= '0;
    end
    else
    begin
      active_q <= active;
      if (active)
      begin
        armed     <= 1'b1;
        clear_cnt <= '0;
      end
      else if (recover)
        armed <= 1'b0;
      else if (armed && tick)
        clear_cnt <= clear_cnt + (LW+1)'(1);
    end
  end

  // ----------------------------------------------------------------------
  // recovery counter and latch, set wins over reset
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rec_count <= '0;
    else if (recover && rec_count != '1)
      rec_count <= rec_count + LW'(1);
    else if (evt_reset)
      rec_count <= '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      latched <= 1'b0;
    else if (latch_set)
      latched <= 1'b1;
    else if (evt_reset)
      latched <= 1'b0;
  end

  a_latch_on_limit: assert property (@(posedge sys_clk) disable iff (rst)
    occur && rec_count >= max_limit |=> latched)
    else $error("event did not latch at its limit");

  a_latch_holds: assert property (@(posedge sys_clk) disable iff (rst)
    latched && !evt_reset |=> latched)
    else $error("latched event released without reset");

  a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
    recover && rec_count != '1 |=> rec_count == $past(rec_count) + LW'(1))
    else $error("recovery counter did not advance");

  a_count_own: assert property (@(posedge sys_clk) disable iff (rst)
    !recover && !evt_reset |=> $stable(rec_count))
    else $error("recovery counter moved without own cause");

  a_no_early_count: assert property (@(posedge sys_clk) disable iff (rst)
    active |=> !recover)
    else $error("recovery counted right after activity");

endmodule : erl_event_unit

`default_nettype wire

// *** erl_limiter_top.sv ***
// Purpose: event recovery limiter with Avalon-MM register access
// Assumes: event inputs synchronous to sys_clk, one wait state per access
// Notes:   bridge may be enabled only when no event latched or disabling
`default_nettype none

module erl_limiter_top
  import erl_pkg::*;
#(
  parameter int N_EVT       = ERL_N_EVT,
  parameter int TICK_CYCLES = ERL_TICK_CYCLES
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [ERL_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [N_EVT-1:0]      event_active,
  input  wire logic                  bridge_enable_request,
  output logic                       bridge_enable,
  output logic      [N_EVT-1:0]      event_report,
  output logic      [N_EVT-1:0]      event_latched
);

  localparam int LW = ERL_LIMIT_W;

  generate
    if (N_EVT != ERL_N_EVT)
    begin : g_bad_n
      $error("erl_limiter_top: N_EVT must match the register map");
    end
    if (ERL_ACT_W * N_EVT > LW)
    begin : g_bad_act
      $error("erl_limiter_top: action and status fields must fit one register");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [LW-1:0]          action_reg;
  logic [LW-1:0]          timeout_reg;
  logic [LW-1:0]          recovery_reg;
  logic [LW-1:0]          limit_reg [N_EVT];
  logic [LW-1:0]          rec_count [N_EVT];
  logic [N_EVT-1:0]       latched;
  logic [N_EVT-1:0]       disabling;
  logic [N_EVT-1:0]       reporting;
  logic [N_EVT-1:0]       evt_reset;
  logic [LW:0]            clear_len;
  logic                   tick;
  logic [ERL_IDX_W-1:0]   idx;
  logic                   wr_ok;
  logic [31:0]            next_readdata;

  assign idx       = avs_address[ERL_ADDR_W-1:2];
  assign wr_ok     = avs_write & ~avs_waitrequest;
  assign clear_len = {1'b0, timeout_reg} + {1'b0, recovery_reg};
  assign evt_reset = (wr_ok && idx == ERL_IDX_EVT_RESET && avs_byteenable[0])
                     ? avs_writedata[N_EVT-1:0] : '0;

  function automatic logic [LW-1:0] merge16(input logic [LW-1:0] old,
                                            input logic [31:0]   data,
                                            input logic [3:0]    be);
    logic [LW-1:0] res;
    res       = old;
    if (be[0])
      res[7:0]  = data[7:0];
    if (be[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // ----------------------------------------------------------------------
  // Avalon-MM slave: one wait state, then answer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  always_comb
  begin
    next_readdata = '0;
    if (idx == ERL_IDX_ACTION)
      next_readdata[LW-1:0] = action_reg;
    else if (idx == ERL_IDX_TIMEOUT)
      next_readdata[LW-1:0] = timeout_reg;
    else if (idx == ERL_IDX_RECOVERY)
      next_readdata[LW-1:0] = recovery_reg;
    else if (idx == ERL_IDX_STATUS)
      next_readdata[LW-1:0] = {event_active, latched};
    for (int i = 0; i < N_EVT; i++)
    begin
      if (idx == ERL_IDX_LIMIT[i])
        next_readdata[LW-1:0] = limit_reg[i];
      if (idx == ERL_IDX_COUNT0 + ERL_IDX_W'(i))
        next_readdata[LW-1:0] = rec_count[i];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      avs_readdata <= '0;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= next_readdata;
    else
      avs_readdata <= '0;
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      action_reg   <= ERL_ACTION_RST;
      timeout_reg  <= ERL_TIMEOUT_RST;
      recovery_reg <= ERL_RECOVERY_RST;
    end
    else if (wr_ok)
    begin
      if (idx == ERL_IDX_ACTION)
        action_reg <= merge16(action_reg, avs_writedata, avs_byteenable);
      if (idx == ERL_IDX_TIMEOUT)
        timeout_reg <= merge16(timeout_reg, avs_writedata, avs_byteenable);
      if (idx == ERL_IDX_RECOVERY)
        recovery_reg <= merge16(recovery_reg, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < N_EVT; i++)
        limit_reg[i] <= ERL_LIMIT_RST;
    end
    else if (wr_ok)
    begin
      for (int i = 0; i < N_EVT; i++)
        if (idx == ERL_IDX_LIMIT[i])
          limit_reg[i] <= merge16(limit_reg[i], avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------------
  // timebase and per-event supervision
  // ----------------------------------------------------------------------
  erl_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick)
  );

  genvar g;
  generate
    for (g = 0; g < N_EVT; g++)
    begin : g_evt
      erl_event_unit #(
        .LW (LW)
      ) u_unit (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .tick      (tick),
        .active    (event_active[g]),
        .max_limit (limit_reg[g]),
        .clear_len (clear_len),
        .evt_reset (evt_reset[g]),
        .latched   (latched[g]),
        .rec_count (rec_count[g])
      );
      // action decode
      assign disabling[g] = event_active[g] & action_reg[ERL_ACT_W*g+1];
      assign reporting[g] = event_active[g] &
                            (action_reg[ERL_ACT_W*g +: ERL_ACT_W] != ERL_ACT_IGNORE);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bridge_enable <= 1'b0;
      event_report  <= '0;
      event_latched <= '0;
    end
    else
    begin
      bridge_enable <= bridge_enable_request & ~|latched & ~|disabling;
      event_report  <= reporting;
      event_latched <= latched;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_bridge_latch_off: assert property (@(posedge sys_clk) disable iff (rst)
    |latched |=> !bridge_enable)
    else $error("bridge enabled while an event is latched");

  a_action_disable: assert property (@(posedge sys_clk) disable iff (rst)
    event_active[0] && action_reg[1] |=> !bridge_enable)
    else $error("disable action did not stop the bridge");

  a_action_report: assert property (@(posedge sys_clk) disable iff (rst)
    event_active[1] && action_reg[3:2] != ERL_ACT_IGNORE |=> event_report[1])
    else $error("report action missing");

  a_limit_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ok && idx == ERL_IDX_ZERO_VEL && avs_byteenable[1:0] == 2'h3
    |=> limit_reg[0] == $past(avs_writedata[15:0]))
    else $error("limit write lost");

  a_limit_readback: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && avs_waitrequest && idx == ERL_IDX_POS_FOLLOW
    |=> avs_readdata[15:0] == limit_reg[7] && avs_readdata[31:16] == 16'h0000)
    else $error("limit readback wrong");

  a_wait_one: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("slave answer not one wait state");

  a_reset_release: assert property (@(posedge sys_clk) disable iff (rst)
    evt_reset[5] && !event_active[5] && latched[5] |=> !latched[5])
    else $error("event reset did not release latch");

  a_counter_isolated: assert property (@(posedge sys_clk) disable iff (rst)
    evt_reset == 8'h01 |=> rec_count[1] >= $past(rec_count[1]))
    else $error("reset of one event touched another counter");

  // ----------------------------------------------------------------------
  // bridge, action, latch, counter and bus checks
  // ----------------------------------------------------------------------
  a_bridge_needs_req: assert property (@(posedge sys_clk) disable iff (rst)
    !bridge_enable_request |=> !bridge_enable)
    else $error("bridge enabled without a request");

  a_report_ignore: assert property (@(posedge sys_clk) disable iff (rst)
    event_active[0] && action_reg[1:0] == ERL_ACT_IGNORE |=> !event_report[0])
    else $error("ignored event was reported");

  a_disable_alt: assert property (@(posedge sys_clk) disable iff (rst)
    event_active[3] && action_reg[7:6] == ERL_ACT_DIS_ALT |=> !bridge_enable)
    else $error("alternate disable action did not stop the bridge");

  a_latched_mirror: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> event_latched == $past(latched))
    else $error("latched output does not follow the latches");

  a_reset_clears_count: assert property (@(posedge sys_clk) disable iff (rst)
    evt_reset[0] && !g_evt[0].u_unit.recover |=> rec_count[0] == '0)
    else $error("event reset did not clear its counter");

  a_read_idle_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !avs_waitrequest |=> avs_readdata == '0)
    else $error("read data not cleared after the answer");

  a_write_needs_wait: assert property (@(posedge sys_clk) disable iff (rst)
    avs_waitrequest |=> $stable(action_reg))
    else $error("register written before the answer cycle");

  a_status_read: assert property (@(posedge sys_clk) disable iff (rst)
    avs_read && avs_waitrequest && idx == ERL_IDX_STATUS
    |=> avs_readdata[LW-1:0] == {$past(event_active), $past(latched)})
    else $error("status readback wrong");

  a_wait_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  c_latch: cover property (@(posedge sys_clk) disable iff (rst) $rose(latched[0]));
  c_recover: cover property (@(posedge sys_clk) disable iff (rst)
    rec_count[0] != $past(rec_count[0]) && rec_count[0] != '0);
  c_reenable: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(event_latched[0]) ##[1:4] bridge_enable);
  c_count_reset: cover property (@(posedge sys_clk) disable iff (rst)
    evt_reset[5] && rec_count[5] != '0);
  c_bridge_held: cover property (@(posedge sys_clk) disable iff (rst)
    bridge_enable_request && |latched && !bridge_enable);

endmodule : erl_limiter_top

`default_nettype wire

// *** erl_pkg.sv ***
// Purpose: shared constants for the event recovery limiter
// Assumes: 10 MHz system clock, Avalon-MM word registers at four times their index
// Notes:   indices are register numbers, byte address = index * 4
`default_nettype none

package erl_pkg;

  // ----------------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------------
  localparam int ERL_N_EVT       = 8;
  localparam int ERL_LIMIT_W     = 16;
  localparam int ERL_ADDR_W      = 12;
  localparam int ERL_IDX_W       = 10;
  localparam int ERL_CLK_HZ      = 10_000_000;
  localparam int ERL_TICK_US     = 1000;
  localparam int ERL_TICK_CYCLES = ERL_TICK_US * (ERL_CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [9:0] ERL_IDX_ZERO_VEL    = 10'h30a;
  localparam logic [9:0] ERL_IDX_VEL_FOLLOW  = 10'h30b;
  localparam logic [9:0] ERL_IDX_POS_VEL_LIM = 10'h30c;
  localparam logic [9:0] ERL_IDX_NEG_VEL_LIM = 10'h30d;
  localparam logic [9:0] ERL_IDX_MAX_MEAS    = 10'h30e;
  localparam logic [9:0] ERL_IDX_MIN_MEAS    = 10'h30f;
  localparam logic [9:0] ERL_IDX_AT_HOME     = 10'h310;
  localparam logic [9:0] ERL_IDX_POS_FOLLOW  = 10'h311;
  localparam logic [9:0] ERL_IDX_LIMIT [ERL_N_EVT] = '{
    ERL_IDX_ZERO_VEL, ERL_IDX_VEL_FOLLOW, ERL_IDX_POS_VEL_LIM, ERL_IDX_NEG_VEL_LIM,
    ERL_IDX_MAX_MEAS, ERL_IDX_MIN_MEAS, ERL_IDX_AT_HOME, ERL_IDX_POS_FOLLOW};
  localparam logic [9:0] ERL_IDX_ACTION      = 10'h300;
  localparam logic [9:0] ERL_IDX_TIMEOUT     = 10'h301;
  localparam logic [9:0] ERL_IDX_RECOVERY    = 10'h302;
  localparam logic [9:0] ERL_IDX_STATUS      = 10'h303;
  localparam logic [9:0] ERL_IDX_EVT_RESET   = 10'h304;
  localparam logic [9:0] ERL_IDX_COUNT0      = 10'h320;

  // ----------------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------------
  localparam logic [15:0] ERL_ACTION_RST   = 16'haaaa;
  localparam logic [15:0] ERL_TIMEOUT_RST  = 16'h000a;
  localparam logic [15:0] ERL_RECOVERY_RST = 16'h000a;
  localparam logic [15:0] ERL_LIMIT_RST    = 16'h0003;
  localparam int          ERL_ACT_W        = 2;
  localparam int          ERL_STAT_ACT_LSB = 8;

  typedef enum logic [1:0] {
    ERL_ACT_IGNORE  = 2'h0,
    ERL_ACT_REPORT  = 2'h1,
    ERL_ACT_DISABLE = 2'h2,
    ERL_ACT_DIS_ALT = 2'h3
  } erl_action_t;

endpackage : erl_pkg

`default_nettype wire

// *** erl_tick_gen.sv ***
// Purpose: one-cycle timebase pulse for the recovery timers
// Assumes: single clock, synchronous active-high reset
// Notes:   period is a parameter so a bench can shorten it
`default_nettype none

module erl_tick_gen
  import erl_pkg::*;
#(
  parameter int TICK_CYCLES = ERL_TICK_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);

  generate
    if (TICK_CYCLES < 1)
    begin : g_bad
      $error("erl_tick_gen: TICK_CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] div_cnt;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end
    else if (div_cnt == CW'(TICK_CYCLES - 1))
    begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + CW'(1);
      tick    <= 1'b0;
    end
  end

endmodule : erl_tick_gen

`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the event recovery limiter
// Assumes: one wait state per bus access, tick shortened to 4 clocks
// Notes:   every scenario is its own task; inputs driven by nba at the rising edge
`default_nettype none

module tb_top
  import erl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------------
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic [ERL_ADDR_W-1:0] avs_address = '0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = '0;
  logic [3:0]            avs_byteenable = '0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [7:0]            event_active = '0;
  logic                  bridge_enable_request = 1'b0;
  logic                  bridge_enable;
  logic [7:0]            event_report;
  logic [7:0]            event_latched;
  int                    err_total = 0;
  int                    check_count = 0;
  logic [31:0]           rd;

  always #50 sys_clk = ~sys_clk;

  erl_limiter_top #(.N_EVT(8), .TICK_CYCLES(4)) dut
  (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (avs_byteenable),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .event_active          (event_active),
    .bridge_enable_request (bridge_enable_request),
    .bridge_enable         (bridge_enable),
    .event_report          (event_report),
    .event_latched         (event_latched)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic do_reset;
    rst <= 1'b1;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
  endtask : do_reset

  // hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
                     input logic [3:0] be, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address    <= {idx, 2'b00};
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0000, wd};
    avs_byteenable <= be;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      chk(avs_waitrequest, 1'b0);
      conclude();
    end
    data = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, 4'hf, d);
  endtask : wr

  task automatic rdv(input logic [9:0] idx, output logic [31:0] d);
    bus(1'b0, idx, 16'h0000, 4'hf, d);
  endtask : rdv

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] v;
    for (int i = 0; i < 8; i++)
    begin
      rdv(ERL_IDX_LIMIT[i], rd);
      chk(rd, 32'h0000_0003);
    end
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 7) ? 16'hffff : (16'hf0f0 ^ 16'(i));
      wr(ERL_IDX_LIMIT[i], v);
    end
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 7) ? 16'hffff : (16'hf0f0 ^ 16'(i));
      rdv(ERL_IDX_LIMIT[i], rd);
      chk(rd, {16'h0000, v});
    end
    bus(1'b1, ERL_IDX_LIMIT[1], 16'h1234, 4'h1, rd);
    rdv(ERL_IDX_LIMIT[1], rd);
    chk(rd, 32'h0000_f034);
    wr(10'h3ff, 16'h5555);
    rdv(10'h3ff, rd);
    chk(rd, 32'h0000_0000);
    rdv(ERL_IDX_ACTION, rd);
    chk(rd, {16'h0000, ERL_ACTION_RST});
    rdv(ERL_IDX_TIMEOUT, rd);
    chk(rd, {16'h0000, ERL_TIMEOUT_RST});
    rdv(ERL_IDX_RECOVERY, rd);
    chk(rd, {16'h0000, ERL_RECOVERY_RST});
    $display("test regs done");
  endtask : t_regs

  task automatic t_action;
    bridge_enable_request <= 1'b1;
    wr(ERL_IDX_ACTION, 16'h00e4);
    cyc(3);
    chk(bridge_enable, 1'b1);
    event_active <= 8'h03;
    cyc(3);
    chk(event_report, 8'h02);
    chk(bridge_enable, 1'b1);
    rdv(ERL_IDX_STATUS, rd);
    chk(rd, 32'h0000_0300);
    event_active <= 8'h07;
    cyc(3);
    chk(event_report, 8'h06);
    chk(bridge_enable, 1'b0);
    event_active <= 8'h0b;
    cyc(3);
    chk(event_report, 8'h0a);
    chk(bridge_enable, 1'b0);
    event_active <= 8'h00;
    cyc(3);
    chk(event_report, 8'h00);
    chk(bridge_enable, 1'b1);
    $display("test action done");
  endtask : t_action

  task automatic t_latch;
    wr(ERL_IDX_ACTION, 16'h0000);
    wr(ERL_IDX_LIMIT[0], 16'h0000);
    event_active <= 8'h01;
    cyc(4);
    chk(event_latched, 8'h01);
    chk(bridge_enable, 1'b0);
    event_active <= 8'h00;
    cyc(30);
    chk(event_latched, 8'h01);
    chk(bridge_enable, 1'b0);
    rdv(ERL_IDX_STATUS, rd);
    chk(rd, 32'h0000_0001);
    bus(1'b1, ERL_IDX_EVT_RESET, 16'h0001, 4'h1, rd);
    cyc(3);
    chk(event_latched, 8'h00);
    chk(bridge_enable, 1'b1);
    rdv(ERL_IDX_EVT_RESET, rd);
    chk(rd, 32'h0000_0000);
    $display("test latch done");
  endtask : t_latch

  task automatic t_recovery;
    wr(ERL_IDX_TIMEOUT, 16'h0001);
    wr(ERL_IDX_RECOVERY, 16'h0002);
    wr(ERL_IDX_LIMIT[5], 16'h0001);
    event_active <= 8'h20;
    cyc(3);
    event_active <= 8'h00;
    cyc(1);
    // too short a clear time must not count yet
    rdv(ERL_IDX_COUNT0 + 10'h005, rd);
    chk(rd, 32'h0000_0000);
    cyc(40);
    rdv(ERL_IDX_COUNT0 + 10'h005, rd);
    chk(rd, 32'h0000_0001);
    rdv(ERL_IDX_COUNT0 + 10'h004, rd);
    chk(rd, 32'h0000_0000);
    cyc(40);
    rdv(ERL_IDX_COUNT0 + 10'h005, rd);
    chk(rd, 32'h0000_0001);
    chk(event_latched, 8'h00);
    event_active <= 8'h20;
    cyc(4);
    chk(event_latched, 8'h20);
    chk(bridge_enable, 1'b0);
    event_active <= 8'h00;
    bus(1'b1, ERL_IDX_EVT_RESET, 16'h0020, 4'h1, rd);
    cyc(3);
    chk(event_latched, 8'h00);
    chk(bridge_enable, 1'b1);
    rdv(ERL_IDX_COUNT0 + 10'h005, rd);
    chk(rd, 32'h0000_0000);
    $display("test recovery done");
  endtask : t_recovery

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    do_reset();
    chk(avs_waitrequest, 1'b1);
    chk(bridge_enable, 1'b0);
    t_regs();
    t_action();
    do_reset();
    bridge_enable_request <= 1'b1;
    t_latch();
    t_recovery();
    conclude();
  end

endmodule : tb_top

`default_nettype wire
